// ===== shared/sifv_pkg.sv
// register map, field positions, reset values and vector codes of the flag/vector block
package sifv_pkg;
   // register byte offsets
   localparam logic [5:0]  OFS_FLAGS      = 6'h00;
   localparam logic [5:0]  OFS_VECTOR     = 6'h04;
   localparam logic [5:0]  OFS_ENABLE     = 6'h08;
   localparam logic [5:0]  OFS_TXBUF      = 6'h0C;
   localparam logic [5:0]  OFS_RXBUF      = 6'h10;
   localparam logic [5:0]  OFS_STATUS     = 6'h14;
   localparam logic [5:0]  OFS_MASK       = 6'h18;
   // field positions
   localparam int          BIT_RX         = 0;
   localparam int          BIT_TX         = 1;
   localparam int          BIT_OVR        = 2;
   // reset values
   localparam logic        RST_TX_FLAG    = 1'b1;
   localparam logic        RST_RX_FLAG    = 1'b0;
   // vector codes
   localparam logic [15:0] VEC_NONE       = 16'h0000;
   localparam logic [15:0] VEC_RX         = 16'h0002;
   localparam logic [15:0] VEC_TX         = 16'h0004;
   // axi responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : sifv_pkg

// ===== shared/sifv_flag_if.sv
`timescale 1ns/10ps
// flag state shared between the register slave and the vector encoder
interface sifv_flag_if;
   logic        rx_complete_flag;
   logic        tx_empty_flag;
   logic [15:0] irq_vector_value;
   modport owner   (output rx_complete_flag, output tx_empty_flag, input irq_vector_value);
   modport encoder (input rx_complete_flag, input tx_empty_flag, output irq_vector_value);
endinterface : sifv_flag_if

// ===== design/sifv_vector.sv
`timescale 1ns/10ps
// priority encoder that builds the interrupt vector value
module sifv_vector (
   sifv_flag_if.encoder fl
);
   // receive wins over transmit
   always_comb begin
      if (fl.rx_complete_flag) begin
         fl.irq_vector_value = sifv_pkg::VEC_RX; // see R4
      end else if (fl.tx_empty_flag) begin
         fl.irq_vector_value = sifv_pkg::VEC_TX; // see R5
      end else begin
         fl.irq_vector_value = sifv_pkg::VEC_NONE; // see R3
      end
   end
endmodule : sifv_vector

// ===== design/sifv_top.sv
// interrupt flag and vector block with axi4-lite register slave
// Behaviour
// R1 - transmit-empty flag sets while transmit buffer empty; resets to 1
// R2 - receive-complete flag sets when a whole character lands; resets to 0
// R3 - vector reads zero when no flag is pending
// R4 - vector reads 0x0002 when receive-complete pending, highest priority
// R5 - vector reads 0x0004 when only transmit-empty pending
// R6 - writing the transmit buffer clears transmit-empty flag
// R7 - reading the receive buffer clears receive-complete and receive error bits
// R8 - interrupt request high while any enabled flag is set
`timescale 1ns/10ps
module sifv_top (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        srst_in,
   // axi4-lite write address
   input  wire logic [5:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // axi4-lite read address
   input  wire logic [5:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // shift engine side
   input  wire logic        rx_char_done_in,
   input  wire logic [7:0]  rx_char_in,
   input  wire logic        rx_overrun_in,
   input  wire logic        tx_load_in,
   output logic [7:0]       tx_data_out,
   output logic             tx_data_valid_out,
   // interrupt lines
   output logic             irq_out,
   output logic             sys_irq_out
);
   sifv_flag_if fl ();

   logic        aw_held_r;
   logic        w_held_r;
   logic [5:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        tx_pending_r;
   logic [7:0]  transmit_buffer_r;
   logic [7:0]  receive_buffer_r;
   logic        rx_flag_r;
   logic        ovr_r;
   logic [1:0]  irq_en_r;
   logic [2:0]  sticky_r;
   logic [2:0]  sticky_mask_r;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_txbuf;
   logic        rd_rxbuf;
   logic        rd_status;
   logic        tx_flag;
   logic [31:0] rd_word;
   logic [2:0]  evt;
   logic        tx_flag_d_r;

   sifv_vector u_vector (
      .fl (fl.encoder)
   );

   // write path: address and data taken in either order
   assign s_axi_awready_out = !aw_held_r && !s_axi_bvalid_out;
   assign s_axi_wready_out  = !w_held_r && !s_axi_bvalid_out;
   assign wr_fire           = aw_held_r && w_held_r && !s_axi_bvalid_out;
   assign wr_txbuf          = wr_fire && aw_addr_r == sifv_pkg::OFS_TXBUF && w_strb_r[0];

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 6'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_in;
         end else if (wr_fire) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
         end else if (wr_fire) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= sifv_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         case (aw_addr_r)
            sifv_pkg::OFS_FLAGS, sifv_pkg::OFS_VECTOR, sifv_pkg::OFS_ENABLE, sifv_pkg::OFS_TXBUF,
            sifv_pkg::OFS_RXBUF, sifv_pkg::OFS_STATUS, sifv_pkg::OFS_MASK: begin
               s_axi_bresp_out <= sifv_pkg::RESP_OKAY;
            end
            default: begin
               s_axi_bresp_out <= sifv_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // read path: one cycle from address to data
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign rd_fire           = s_axi_arvalid_in && s_axi_arready_out;
   assign rd_rxbuf          = rd_fire && s_axi_araddr_in == sifv_pkg::OFS_RXBUF;
   assign rd_status         = rd_fire && s_axi_araddr_in == sifv_pkg::OFS_STATUS;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr_in)
         sifv_pkg::OFS_FLAGS:  rd_word = {30'h0000_0000, tx_flag, rx_flag_r};
         sifv_pkg::OFS_VECTOR: rd_word = {16'h0000, fl.irq_vector_value};
         sifv_pkg::OFS_ENABLE: rd_word = {30'h0000_0000, irq_en_r};
         sifv_pkg::OFS_TXBUF:  rd_word = {24'h00_0000, transmit_buffer_r};
         sifv_pkg::OFS_RXBUF:  rd_word = {24'h00_0000, receive_buffer_r};
         sifv_pkg::OFS_STATUS: rd_word = {29'h0000_0000, sticky_r};
         sifv_pkg::OFS_MASK:   rd_word = {29'h0000_0000, sticky_mask_r};
         default:              rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= 32'h0000_0000;
         s_axi_rresp_out  <= sifv_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out  <= rd_word;
         s_axi_rresp_out  <= (s_axi_araddr_in > sifv_pkg::OFS_MASK || s_axi_araddr_in[1:0] != 2'h0) ?
                             sifv_pkg::RESP_SLVERR : sifv_pkg::RESP_OKAY;
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // transmit buffer: pending until the shift engine loads it
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         tx_pending_r      <= !sifv_pkg::RST_TX_FLAG;
         transmit_buffer_r <= 8'h00;
      end else if (wr_txbuf) begin
         tx_pending_r      <= 1'b1; // see R6
         transmit_buffer_r <= w_data_r[7:0];
      end else if (tx_load_in) begin
         tx_pending_r      <= 1'b0;
      end
   end
   assign tx_flag           = !tx_pending_r; // see R1
   assign tx_data_out       = transmit_buffer_r;
   assign tx_data_valid_out = tx_pending_r;

   // receive buffer and flag; a new character wins over the read clear
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         rx_flag_r        <= sifv_pkg::RST_RX_FLAG;
         ovr_r            <= 1'b0;
         receive_buffer_r <= 8'h00;
      end else if (rx_char_done_in) begin
         rx_flag_r        <= 1'b1; // see R2
         ovr_r            <= rx_flag_r || rx_overrun_in;
         receive_buffer_r <= rx_char_in;
      end else if (rd_rxbuf) begin
         rx_flag_r        <= 1'b0; // see R7
         ovr_r            <= 1'b0;
      end
   end

   assign fl.rx_complete_flag = rx_flag_r;
   assign fl.tx_empty_flag    = tx_flag;

   // enable and mask registers
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         irq_en_r      <= 2'h0;
         sticky_mask_r <= 3'h0;
      end else if (wr_fire && w_strb_r[0]) begin
         if (aw_addr_r == sifv_pkg::OFS_ENABLE) irq_en_r <= w_data_r[1:0];
         if (aw_addr_r == sifv_pkg::OFS_MASK) sticky_mask_r <= w_data_r[2:0];
      end
   end

   // sticky event status, cleared by reading; set wins
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         tx_flag_d_r <= sifv_pkg::RST_TX_FLAG; // same level as the flag, no false rise after reset
      end else begin
         tx_flag_d_r <= tx_flag;
      end
   end
   assign evt = {rx_char_done_in && rx_flag_r, tx_flag && !tx_flag_d_r, rx_char_done_in};
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         sticky_r <= 3'h0;
      end else begin
         sticky_r <= (rd_status ? 3'h0 : sticky_r) | evt;
      end
   end

   // interrupt outputs
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         irq_out     <= 1'b0;
         sys_irq_out <= 1'b0;
      end else begin
         irq_out     <= (rx_flag_r && irq_en_r[sifv_pkg::BIT_RX]) || (tx_flag && irq_en_r[sifv_pkg::BIT_TX]); // see R8
         sys_irq_out <= |(sticky_r & sticky_mask_r);
      end
   end

   // checks
   AST_VEC_RX: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      rx_flag_r |-> fl.irq_vector_value == 16'h0002) else $error("vector not rx"); // see R4
   AST_VEC_TX: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      !rx_flag_r && tx_flag |-> fl.irq_vector_value == 16'h0004) else $error("vector not tx"); // see R5
   AST_VEC_NONE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      !rx_flag_r && !tx_flag |-> fl.irq_vector_value == 16'h0000) else $error("vector not zero"); // see R3
   AST_TX_CLR: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      wr_txbuf |=> !tx_flag) else $error("tx flag not cleared"); // see R6
   AST_TX_SET: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      tx_load_in && !wr_txbuf |=> tx_flag) else $error("tx flag not set"); // see R1
   AST_RX_SET: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      rx_char_done_in |=> rx_flag_r && receive_buffer_r == $past(rx_char_in)) else $error("rx not set"); // see R2
   AST_RX_CLR: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      rd_rxbuf && !rx_char_done_in |=> !rx_flag_r && !ovr_r) else $error("rx not cleared"); // see R7
   AST_IRQ: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      ##1 irq_out == $past((rx_flag_r && irq_en_r[0]) || (tx_flag && irq_en_r[1]))) else $error("irq wrong"); // see R8
endmodule : sifv_top

// ===== testbench/sifv_top_tb.sv
// self-checking bench for the interrupt flag and vector block
`timescale 1ns/10ps
module sifv_top_tb;
   logic        clk_sys_in, srst_in;
   logic [5:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        rx_done, rx_ovr, tx_load, tx_valid, irq, sys_irq;
   logic [7:0]  rx_char, tx_data;
   int          error_cnt, num_checks, cyc;
   logic [31:0] rd_data;
   logic [1:0]  rd_resp;

   // device under test, every input driven by the bench
   sifv_top i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .rx_char_done_in(rx_done), .rx_char_in(rx_char), .rx_overrun_in(rx_ovr), .tx_load_in(tx_load),
      .tx_data_out(tx_data), .tx_data_valid_out(tx_valid), .irq_out(irq), .sys_irq_out(sys_irq));

   // 200 mhz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // hang guard
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // axi write, address and data offered together
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_sys_in);
         if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge clk_sys_in); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge clk_sys_in);
      check({30'h0, bresp}, {30'h0, er});
   endtask : wr

   // axi read
   task automatic rd(input logic [5:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk_sys_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_sys_in); while (rvalid !== 1'b1);
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
      @(posedge clk_sys_in);
   endtask : rd

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      rd(a);
      check(rd_data, exp);
      check({30'h0, rd_resp}, {30'h0, sifv_pkg::RESP_OKAY});
   endtask : rd_chk

   // one-cycle event pulses from the shift engine
   task automatic rx_pulse(input logic [7:0] d, input logic ov);
      rx_done <= 1'b1; rx_char <= d; rx_ovr <= ov;
      @(posedge clk_sys_in);
      rx_done <= 1'b0; rx_ovr <= 1'b0;
      @(posedge clk_sys_in);
   endtask : rx_pulse

   task automatic tx_pulse();
      tx_load <= 1'b1;
      @(posedge clk_sys_in);
      tx_load <= 1'b0;
      @(posedge clk_sys_in);
   endtask : tx_pulse

   task automatic settle();
      repeat (3) @(posedge clk_sys_in);
   endtask : settle

   // reset values of flags and vector
   task automatic s_reset();
      rd_chk(sifv_pkg::OFS_FLAGS, 32'h0000_0002);
      rd_chk(sifv_pkg::OFS_STATUS, 32'h0000_0000);
      rd_chk(sifv_pkg::OFS_VECTOR, 32'h0000_0004);
      settle();
      check({29'h0, irq, sys_irq, tx_valid}, 32'h0);
   endtask : s_reset

   // transmit buffer write and hand-off
   task automatic s_tx();
      rd(sifv_pkg::OFS_STATUS);
      wr(sifv_pkg::OFS_TXBUF, 32'h0000_00A5, sifv_pkg::RESP_OKAY);
      rd_chk(sifv_pkg::OFS_FLAGS, 32'h0);
      rd_chk(sifv_pkg::OFS_VECTOR, 32'h0);
      check({23'h0, tx_valid, tx_data}, 32'h0000_01A5);
      tx_pulse();
      rd_chk(sifv_pkg::OFS_FLAGS, 32'h0000_0002);
      rd_chk(sifv_pkg::OFS_STATUS, 32'h0000_0002);
      rd_chk(sifv_pkg::OFS_VECTOR, 32'h0000_0004);
   endtask : s_tx

   // receive, priority over transmit, overrun and buffer read
   task automatic s_rx();
      rx_pulse(8'h3C, 1'b0);
      rd_chk(sifv_pkg::OFS_FLAGS, 32'h0000_0003);
      rd_chk(sifv_pkg::OFS_VECTOR, 32'h0000_0002);
      rx_pulse(8'h5A, 1'b1);
      rd_chk(sifv_pkg::OFS_STATUS, 32'h0000_0005);
      rd_chk(sifv_pkg::OFS_RXBUF, 32'h0000_005A);
      rd_chk(sifv_pkg::OFS_FLAGS, 32'h0000_0002);
      rd_chk(sifv_pkg::OFS_VECTOR, 32'h0000_0004);
   endtask : s_rx

   // enabled flags, status mask and unmapped access
   task automatic s_irq();
      wr(sifv_pkg::OFS_ENABLE, 32'h0000_0002, sifv_pkg::RESP_OKAY);
      settle();
      check({31'h0, irq}, 32'h1);
      wr(sifv_pkg::OFS_ENABLE, 32'h0000_0001, sifv_pkg::RESP_OKAY);
      settle();
      check({31'h0, irq}, 32'h0);
      wr(sifv_pkg::OFS_MASK, 32'h0000_0001, sifv_pkg::RESP_OKAY);
      rd(sifv_pkg::OFS_STATUS);
      rx_pulse(8'h11, 1'b0);
      settle();
      check({30'h0, irq, sys_irq}, 32'h3);
      rd_chk(sifv_pkg::OFS_RXBUF, 32'h0000_0011);
      rd_chk(sifv_pkg::OFS_STATUS, 32'h0000_0001);
      settle();
      check({30'h0, irq, sys_irq}, 32'h0);
      rd(6'h1C);
      check({rd_data[29:0], rd_resp}, {30'h0, sifv_pkg::RESP_SLVERR});
      wr(6'h1C, 32'h0000_0003, sifv_pkg::RESP_SLVERR);
   endtask : s_irq

   // reset in mid-run with flags dirty brings all back to reset values
   task automatic s_midrst();
      wr(sifv_pkg::OFS_TXBUF, 32'h0000_005A, sifv_pkg::RESP_OKAY);
      rx_pulse(8'h77, 1'b1);
      srst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      @(posedge clk_sys_in);
      s_reset();
   endtask : s_midrst

   // main sequence
   initial begin
      error_cnt = 0; num_checks = 0; cyc = 0;
      srst_in = 1'b1; awaddr = 6'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hF; wvalid = 1'b0;
      bready = 1'b0; araddr = 6'h00; arvalid = 1'b0; rready = 1'b0;
      rx_done = 1'b0; rx_char = 8'h00; rx_ovr = 1'b0; tx_load = 1'b0;
      repeat (3) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      @(posedge clk_sys_in);
      s_reset();
      s_tx();
      s_rx();
      s_irq();
      s_midrst();
      summarize();
   end
endmodule : sifv_top_tb
